// [hdl/fwg_guard.sv]
// Flash write guard: store control, key, page lock and access arbitration
// Function
// - Writes need write enable; erases need both enables
// - Lock byte complement counts locked pages from zero
// - Lock byte page locked when any lock bit zero
// - Unlocked ordinary pages open to every requester
// - Locked pages: debug refused, unlocked firmware errors
// - Locked lock page: same treatment as locked pages
// - Lock byte read guarded like locked lock page
// - Unlocked lock page: debug erase ok, firmware errors
// - Locked lock page erasable only by device erase
// - Changing written lock byte refused or errors
// - Reserved area: debug refused, firmware errors
// - Error reset pulses; error flag then reads one
// - Debug violations ignored without reset
// - Written lock byte frozen except device erase
// - Lock value takes effect only after reset
// - Upper six control bits read zero
// - Both enables: data move write erases page
// - Write enable steers data move write to flash
// - Key sequence A5 then F1 arms flash
// - Arming ends after each completed firmware write or erase
// - Wrong key or unarmed attempt disables until reset
// - Key register reads lock state code
// - Program clears bits; only erase sets them
`timescale 1ns/1ps
`default_nettype none
module fwg_guard (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        por,
   input  wire logic [7:0]  lock_byte_in,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        cpu_req,
   input  wire logic        cpu_op,
   input  wire logic [12:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic [12:0] cpu_pc,
   input  wire logic        dbg_req,
   input  wire logic [1:0]  dbg_op,
   input  wire logic [12:0] dbg_addr,
   input  wire logic [7:0]  dbg_wdata,
   input  wire logic        flash_done,
   output logic             busy,
   output logic             cmd_valid,
   output logic      [1:0]  cmd_op,
   output logic      [12:0] cmd_addr,
   output logic      [7:0]  cmd_wdata,
   output logic             dbg_refused,
   output logic             err_reset,
   output logic             flash_error_flag
);
   logic [7:0]  lock_byte;
   logic        lock_loaded;
   logic [1:0]  store_ctl;
   logic        key_open;
   logic [1:0]  key_code;
   logic        key_wr;
   logic        cpu_flash;
   logic [1:0]  cpu_kind;
   logic        cpu_try;
   logic [1:0]  cpu_verdict;
   logic [1:0]  dbg_verdict;
   logic        any_locked;
   logic        take_cpu;
   logic        take_dbg;
   logic        op_done;

   // True when a page sits inside the locked region
   function automatic logic page_locked(input logic [12:0] addr, input logic [7:0] lock);
      logic [3:0] page;
      logic [3:0] lock_page;
      logic [7:0] count;
      page      = addr[12:fwg_pkg::PAGE_LSB];
      lock_page = fwg_pkg::LOCK_BYTE_ADDR[12:fwg_pkg::PAGE_LSB];
      count     = ~lock;
      page_locked = ({4'h0, page} < count) ||
                    ((page == lock_page) && (lock != fwg_pkg::LOCK_ERASED));
   endfunction

   // Verdict for one access; dbg selects debug treatment, fw_lck firmware on locked page
   function automatic logic [1:0] judge(input logic [12:0] addr, input logic [1:0] kind,
                                        input logic dbg, input logic fw_lck,
                                        input logic [7:0] lock);
      logic restricted;
      logic lock_pg;
      logic locked_any;
      logic [1:0] deny;
      locked_any = (lock != fwg_pkg::LOCK_ERASED);
      lock_pg    = addr[12:fwg_pkg::PAGE_LSB] ==
                   fwg_pkg::LOCK_BYTE_ADDR[12:fwg_pkg::PAGE_LSB];
      deny       = dbg ? fwg_pkg::V_REFUSE : fwg_pkg::V_ERROR;
      restricted = page_locked(addr, lock);
      if (kind == fwg_pkg::CMD_DEV_ERASE) begin
         judge = fwg_pkg::V_PERMIT;
      end else if (addr > fwg_pkg::LOCK_BYTE_ADDR) begin
         judge = deny;
      end else if ((kind == fwg_pkg::CMD_PAGE_ERASE) && lock_pg) begin
         judge = (dbg && !locked_any) ? fwg_pkg::V_PERMIT : deny;
      end else if ((kind == fwg_pkg::CMD_PROGRAM) && (addr == fwg_pkg::LOCK_BYTE_ADDR)
                   && locked_any) begin
         judge = deny;
      end else if (restricted) begin
         judge = (!dbg && fw_lck) ? fwg_pkg::V_PERMIT : deny;
      end else begin
         judge = fwg_pkg::V_PERMIT;
      end
   endfunction

   // Lock byte is caught once after reset release; later flash writes do not reach it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_loaded <= 1'b0;
         lock_byte   <= fwg_pkg::LOCK_ERASED;
      end else if (!lock_loaded) begin
         lock_loaded <= 1'b1;
         lock_byte   <= lock_byte_in;
      end
   end

   assign any_locked = (lock_byte != fwg_pkg::LOCK_ERASED);

   // Store control register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         store_ctl <= fwg_pkg::CTL_RESET[1:0];
      end else if (sfr_wr && (sfr_addr == fwg_pkg::CTL_OFFSET)) begin
         store_ctl <= sfr_wdata[1:0];
      end
   end

   // Read data for the two registers, other addresses read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_addr == fwg_pkg::CTL_OFFSET) begin
         sfr_rdata <= {6'b00_0000, store_ctl};
      end else if (sfr_addr == fwg_pkg::KEY_OFFSET) begin
         sfr_rdata <= {6'b00_0000, key_code};
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   assign key_wr = sfr_wr && (sfr_addr == fwg_pkg::KEY_OFFSET);

   // Data move writes only target flash while write enable is set
   always_comb begin
      cpu_flash = (cpu_op == fwg_pkg::CPU_READ) || store_ctl[fwg_pkg::CTL_WE_BIT];
      if (cpu_op == fwg_pkg::CPU_READ) begin
         cpu_kind = fwg_pkg::CMD_READ;
      end else if (store_ctl[fwg_pkg::CTL_EE_BIT]) begin
         cpu_kind = fwg_pkg::CMD_PAGE_ERASE;
      end else begin
         cpu_kind = fwg_pkg::CMD_PROGRAM;
      end
   end

   assign cpu_verdict = judge(cpu_addr, cpu_kind, 1'b0,
                              page_locked(cpu_pc, lock_byte), lock_byte);
   assign dbg_verdict = judge(dbg_addr, dbg_op, 1'b1, 1'b0, lock_byte);

   // Core has priority; a waiting requester keeps its request up
   // Nothing is judged before the lock value is loaded, so early requests just wait
   assign take_cpu = cpu_req && cpu_flash && !busy && lock_loaded && !err_reset;
   assign take_dbg = dbg_req && !cpu_req && !busy && lock_loaded && !err_reset;
   assign cpu_try  = take_cpu && (cpu_op == fwg_pkg::CPU_WRITE) &&
                     (cpu_verdict == fwg_pkg::V_PERMIT);

   fwg_key_seq u_key (
      .core_clk  (core_clk),
      .rst       (rst),
      .key_wr    (key_wr),
      .key_wdata (sfr_wdata),
      .op_try    (cpu_try),
      .op_done   (op_done),
      .key_open  (key_open),
      .key_code  (key_code)
   );

   // Firmware write or erase in flight clears arming at completion
   logic fw_mod;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fw_mod <= 1'b0;
      end else if (cpu_try && key_open) begin
         fw_mod <= 1'b1;
      end else if (flash_done) begin
         fw_mod <= 1'b0;
      end
   end
   assign op_done = fw_mod && flash_done;

   // Flash command issue; page erase sets bytes to FF, program only clears bits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy      <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_op    <= fwg_pkg::CMD_READ;
         cmd_addr  <= 13'h0000;
         cmd_wdata <= 8'h00;
      end else begin
         cmd_valid <= 1'b0;
         if (busy && flash_done) begin
            busy <= 1'b0;
         end
         if (take_cpu && (cpu_verdict == fwg_pkg::V_PERMIT) &&
             ((cpu_op == fwg_pkg::CPU_READ) || key_open)) begin
            busy      <= 1'b1;
            cmd_valid <= 1'b1;
            cmd_op    <= cpu_kind;
            cmd_addr  <= cpu_addr;
            cmd_wdata <= cpu_wdata;
         end else if (take_dbg && (dbg_verdict == fwg_pkg::V_PERMIT)) begin
            busy      <= 1'b1;
            cmd_valid <= 1'b1;
            cmd_op    <= dbg_op;
            cmd_addr  <= dbg_addr;
            cmd_wdata <= dbg_wdata;
         end
      end
   end

   // Violations: core forces a reset, debug is just dropped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         err_reset   <= 1'b0;
         dbg_refused <= 1'b0;
      end else begin
         err_reset   <= take_cpu && (cpu_verdict == fwg_pkg::V_ERROR);
         dbg_refused <= take_dbg && (dbg_verdict == fwg_pkg::V_REFUSE);
      end
   end

   // Survives the device reset it causes; only power-on clears it
   always_ff @(posedge core_clk) begin
      if (por) begin
         flash_error_flag <= 1'b0;
      end else if (err_reset) begin
         flash_error_flag <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // Checks are off while reset holds; the error flag is left to power-on clear
   a_ctl_upper_zero: assert property (
      ##1 $past(sfr_addr) == fwg_pkg::CTL_OFFSET |-> sfr_rdata[7:2] == 6'b00_0000)
      else $error("control upper bits not zero");
   a_key_seq_open: assert property (
      key_code == fwg_pkg::KEY_CODE_FIRST && key_wr && sfr_wdata == fwg_pkg::KEY_SECOND
      |=> key_code == fwg_pkg::KEY_CODE_OPEN)
      else $error("second key did not arm");
   a_key_bad_dead: assert property (
      key_code == fwg_pkg::KEY_CODE_LOCKED && key_wr && sfr_wdata != fwg_pkg::KEY_FIRST
      |=> key_code == fwg_pkg::KEY_CODE_DEAD)
      else $error("wrong key did not disable");
   a_dead_stays: assert property (
      key_code == fwg_pkg::KEY_CODE_DEAD |=> key_code == fwg_pkg::KEY_CODE_DEAD)
      else $error("disabled state left");
   a_rearm_after_op: assert property (
      op_done && !key_wr && key_code == fwg_pkg::KEY_CODE_OPEN
      |=> key_code == fwg_pkg::KEY_CODE_LOCKED)
      else $error("arming not ended after op");
   a_no_we_no_prog: assert property (
      cmd_valid && (cmd_op == fwg_pkg::CMD_PROGRAM || cmd_op == fwg_pkg::CMD_PAGE_ERASE)
      && $past(take_cpu) |-> $past(store_ctl[fwg_pkg::CTL_WE_BIT]) && $past(key_open))
      else $error("flash modified without enables");
   a_erase_both_en: assert property (
      take_cpu && cpu_op == fwg_pkg::CPU_WRITE && store_ctl == 2'b11 && key_open
      && cpu_verdict == fwg_pkg::V_PERMIT |=> cmd_valid && cmd_op == fwg_pkg::CMD_PAGE_ERASE)
      else $error("page erase not issued");
   a_dbg_no_reset: assert property (
      take_dbg && dbg_verdict != fwg_pkg::V_PERMIT |=> dbg_refused && !err_reset && !cmd_valid)
      else $error("debug violation mishandled");
   a_reserved_err: assert property (
      take_cpu && cpu_addr > fwg_pkg::LOCK_BYTE_ADDR |=> err_reset && !cmd_valid)
      else $error("reserved access not trapped");
   a_flag_sets: assert property (
      err_reset && !por |=> flash_error_flag)
      else $error("error flag not set");
   a_lock_page_erase: assert property (
      take_cpu && cpu_kind == fwg_pkg::CMD_PAGE_ERASE &&
      cpu_addr[12:9] == fwg_pkg::LOCK_BYTE_ADDR[12:9] |=> err_reset)
      else $error("firmware lock page erase allowed");
   a_unarmed_no_cmd: assert property (
      take_cpu && cpu_op == fwg_pkg::CPU_WRITE && !key_open |=> !cmd_valid)
      else $error("unarmed write reached flash");
   a_locked_fw_err: assert property (
      take_cpu && page_locked(cpu_addr, lock_byte) && !page_locked(cpu_pc, lock_byte)
      |=> err_reset && !cmd_valid)
      else $error("unlocked firmware reached locked page");
   a_dbg_dev_erase: assert property (
      take_dbg && dbg_op == fwg_pkg::DBG_DEV_ERASE
      |=> cmd_valid && cmd_op == fwg_pkg::CMD_DEV_ERASE)
      else $error("device erase not issued");
   a_lock_held: assert property (
      lock_loaded |=> $stable(lock_byte))
      else $error("lock value changed before reset");
   a_key_readback: assert property (
      sfr_addr == fwg_pkg::KEY_OFFSET |=> sfr_rdata == {6'b00_0000, $past(key_code)})
      else $error("key state read back wrong");

   c_page_erase: cover property (cmd_valid && cmd_op == fwg_pkg::CMD_PAGE_ERASE);
   c_err_reset:  cover property (err_reset);
   c_dbg_refuse: cover property (dbg_refused && any_locked);
   c_dev_erase:  cover property (cmd_valid && cmd_op == fwg_pkg::CMD_DEV_ERASE);
endmodule // fwg_guard
`default_nettype wire

// [hdl/fwg_key_seq.sv]
// Two-code key sequence that arms one flash program or erase
`timescale 1ns/1ps
`default_nettype none
module fwg_key_seq (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       key_wr,
   input  wire logic [7:0] key_wdata,
   input  wire logic       op_try,
   input  wire logic       op_done,
   output logic            key_open,
   output logic [1:0]      key_code
);
   fwg_pkg::fwg_key_t state;
   fwg_pkg::fwg_key_t next_state;

   always_comb begin
      next_state = state;
      unique case (state)
         fwg_pkg::FWG_KEY_LOCKED: begin
            if (key_wr) begin
               next_state = (key_wdata == fwg_pkg::KEY_FIRST) ? fwg_pkg::FWG_KEY_FIRST
                                                            : fwg_pkg::FWG_KEY_DEAD;
            end else if (op_try) begin
               next_state = fwg_pkg::FWG_KEY_DEAD;
            end
         end
         fwg_pkg::FWG_KEY_FIRST: begin
            if (key_wr) begin
               next_state = (key_wdata == fwg_pkg::KEY_SECOND) ? fwg_pkg::FWG_KEY_OPEN
                                                             : fwg_pkg::FWG_KEY_DEAD;
            end else if (op_try) begin
               next_state = fwg_pkg::FWG_KEY_DEAD;
            end
         end
         fwg_pkg::FWG_KEY_OPEN: begin
            if (key_wr) begin
               next_state = fwg_pkg::FWG_KEY_DEAD;
            end else if (op_done) begin
               next_state = fwg_pkg::FWG_KEY_LOCKED;
            end
         end
         fwg_pkg::FWG_KEY_DEAD: next_state = fwg_pkg::FWG_KEY_DEAD;
         default:               next_state = fwg_pkg::FWG_KEY_DEAD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= fwg_pkg::FWG_KEY_LOCKED;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_open <= 1'b0;
         key_code <= fwg_pkg::KEY_CODE_LOCKED;
      end else begin
         key_open <= (next_state == fwg_pkg::FWG_KEY_OPEN);
         unique case (next_state)
            fwg_pkg::FWG_KEY_LOCKED: key_code <= fwg_pkg::KEY_CODE_LOCKED;
            fwg_pkg::FWG_KEY_FIRST:  key_code <= fwg_pkg::KEY_CODE_FIRST;
            fwg_pkg::FWG_KEY_OPEN:   key_code <= fwg_pkg::KEY_CODE_OPEN;
            default:                 key_code <= fwg_pkg::KEY_CODE_DEAD;
         endcase
      end
   end
endmodule // fwg_key_seq
`default_nettype wire

// [hdl/fwg_pkg.sv]
// Constants and encodings shared by the flash write guard files
package fwg_pkg;
   localparam int          ADDR_W          = 13;
   localparam int          PAGE_LSB        = 9;
   localparam logic [7:0]  CTL_OFFSET      = 8'h8F;
   localparam logic [7:0]  KEY_OFFSET      = 8'hB7;
   localparam logic [7:0]  CTL_RESET       = 8'h00;
   localparam logic [7:0]  KEY_RESET       = 8'h00;
   localparam int          CTL_WE_BIT      = 0;
   localparam int          CTL_EE_BIT      = 1;
   localparam logic [7:0]  KEY_FIRST       = 8'hA5;
   localparam logic [7:0]  KEY_SECOND      = 8'hF1;
   localparam logic [7:0]  LOCK_ERASED     = 8'hFF;
   localparam logic [12:0] LOCK_BYTE_ADDR  = 13'h1DFF;
   localparam logic [1:0]  KEY_CODE_LOCKED = 2'b00;
   localparam logic [1:0]  KEY_CODE_FIRST  = 2'b01;
   localparam logic [1:0]  KEY_CODE_OPEN   = 2'b10;
   localparam logic [1:0]  KEY_CODE_DEAD   = 2'b11;

   // Requests from the core
   localparam logic        CPU_READ        = 1'b0;
   localparam logic        CPU_WRITE       = 1'b1;

   // Requests from the debug port
   localparam logic [1:0]  DBG_READ        = 2'b00;
   localparam logic [1:0]  DBG_WRITE       = 2'b01;
   localparam logic [1:0]  DBG_PAGE_ERASE  = 2'b10;
   localparam logic [1:0]  DBG_DEV_ERASE   = 2'b11;

   // Commands towards the flash array
   localparam logic [1:0]  CMD_READ        = 2'b00;
   localparam logic [1:0]  CMD_PROGRAM     = 2'b01;
   localparam logic [1:0]  CMD_PAGE_ERASE  = 2'b10;
   localparam logic [1:0]  CMD_DEV_ERASE   = 2'b11;

   // Access verdicts
   localparam logic [1:0]  V_PERMIT        = 2'b00;
   localparam logic [1:0]  V_REFUSE        = 2'b01;
   localparam logic [1:0]  V_ERROR         = 2'b10;

   typedef enum logic [3:0] {
      FWG_KEY_LOCKED = 4'b0001,
      FWG_KEY_FIRST  = 4'b0010,
      FWG_KEY_OPEN   = 4'b0100,
      FWG_KEY_DEAD   = 4'b1000
   } fwg_key_t;
endpackage

// [verification/fwg_flash_model.sv]
// Flash array stand-in that finishes each command after a short or a long delay
`timescale 1ns/1ps
`default_nettype none
module fwg_flash_model #(
   parameter int SLOW = 6
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic cmd_valid,
   input  wire logic slow,
   output logic      flash_done
);
   int cnt;

   // Done is a single pulse; the guard must not start another command before it
   always_ff @(posedge core_clk) begin
      flash_done <= 1'b0;
      if (rst) begin
         cnt <= 0;
      end else if (cmd_valid) begin
         cnt <= slow ? SLOW : 1;
      end else if (cnt == 1) begin
         cnt        <= 0;
         flash_done <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // fwg_flash_model
`default_nettype wire

// [verification/fwg_guard_tb.sv]
// Self-checking bench for the flash write guard with a behavioural access model
`timescale 1ns/1ps
`default_nettype none
module fwg_guard_tb;
   logic        core_clk, rst, por, sfr_wr, cpu_req, cpu_op, dbg_req, slow, flash_done;
   logic        busy, cmd_valid, dbg_refused, err_reset, flash_error_flag;
   logic [7:0]  lock_byte_in, sfr_addr, sfr_wdata, sfr_rdata, cpu_wdata, dbg_wdata, cmd_wdata;
   logic [12:0] cpu_addr, cpu_pc, dbg_addr, cmd_addr;
   logic [1:0]  dbg_op, cmd_op, mps, mkey;
   logic [7:0]  mlock;
   logic [31:0] r;
   int          fail_count, cmp_count;
   integer      seed;

   fwg_guard u_fwg_guard (.core_clk(core_clk), .rst(rst), .por(por),
      .lock_byte_in(lock_byte_in), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_req(cpu_req), .cpu_op(cpu_op),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_pc(cpu_pc), .dbg_req(dbg_req),
      .dbg_op(dbg_op), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .flash_done(flash_done),
      .busy(busy), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .dbg_refused(dbg_refused), .err_reset(err_reset),
      .flash_error_flag(flash_error_flag));

   fwg_flash_model u_fwg_flash_model (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
      .slow(slow), .flash_done(flash_done));

   always #25 core_clk = ~core_clk;

   task automatic test_done();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Page class of an address under the captured lock value
   function automatic logic locked(input logic [12:0] a);
      return (a[12:9] < ~mlock) || (mlock !== 8'hFF &&
             a[12:9] == fwg_pkg::LOCK_BYTE_ADDR[12:9]);
   endfunction

   function automatic logic [1:0] verdict(input logic d, input logic [1:0] op,
                                          input logic [12:0] a, input logic [12:0] pc);
      logic       any, lpg, wr, er;
      logic [1:0] no;
      any = (mlock !== 8'hFF);
      lpg = (a[12:9] == fwg_pkg::LOCK_BYTE_ADDR[12:9]);
      wr  = d ? (op == fwg_pkg::DBG_WRITE) : (op[0] && mps == 2'h1);
      er  = d ? (op == fwg_pkg::DBG_PAGE_ERASE) : (op[0] && mps == 2'h3);
      no  = d ? fwg_pkg::V_REFUSE : fwg_pkg::V_ERROR;
      if (!d && op[0] && !mps[0]) return 2'h3;
      if (d && op == fwg_pkg::DBG_DEV_ERASE) return fwg_pkg::V_PERMIT;
      if (a > fwg_pkg::LOCK_BYTE_ADDR) return no;
      if (er && lpg && (any || !d)) return no;
      if (locked(a) && (d || !locked(pc))) return no;
      if (wr && a == fwg_pkg::LOCK_BYTE_ADDR && any) return no;
      return fwg_pkg::V_PERMIT;
   endfunction

   function automatic logic [12:0] rnd_in(input logic [3:0] pg);
      logic [31:0] v;
      v = $random(seed);
      return {pg, v[8:0]};
   endfunction

   task automatic do_reset(input logic [7:0] lock, input logic clr);
      rst          = 1'b1;
      por          = clr;
      lock_byte_in = lock;
      mlock        = lock;
      mkey         = fwg_pkg::KEY_CODE_LOCKED;
      mps          = 2'h0;
      repeat (8) @(posedge core_clk);
      #1;
      rst = 1'b0;
      por = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] w);
      sfr_addr  = a;
      sfr_wdata = w;
      sfr_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      sfr_wr = 1'b0;
      if (a == fwg_pkg::CTL_OFFSET) mps = w[1:0];
      if (a == fwg_pkg::KEY_OFFSET) begin
         if (mkey == fwg_pkg::KEY_CODE_LOCKED && w == fwg_pkg::KEY_FIRST)
            mkey = fwg_pkg::KEY_CODE_FIRST;
         else if (mkey == fwg_pkg::KEY_CODE_FIRST && w == fwg_pkg::KEY_SECOND)
            mkey = fwg_pkg::KEY_CODE_OPEN;
         else
            mkey = fwg_pkg::KEY_CODE_DEAD;
      end
      @(posedge core_clk);
      #1;
   endtask

   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      @(posedge core_clk);
      #1;
      check("sfr_rdata", exp, sfr_rdata);
   endtask

   task automatic key_seq();
      sfr_write(fwg_pkg::KEY_OFFSET, fwg_pkg::KEY_FIRST);
      sfr_read(fwg_pkg::KEY_OFFSET, {6'h00, mkey});
      sfr_write(fwg_pkg::KEY_OFFSET, fwg_pkg::KEY_SECOND);
      sfr_read(fwg_pkg::KEY_OFFSET, {6'h00, mkey});
   endtask

   task automatic do_req(input logic d, input logic [1:0] op, input logic [12:0] a,
                         input logic [12:0] pc);
      logic [1:0] exp, got, eop;
      logic [31:0] rv;
      exp = verdict(d, op, a, pc);
      got = 2'h3;
      eop = d ? op : (!op[0] ? 2'h0 : (mps[1] ? 2'h2 : 2'h1));
      if (!d && op[0] && exp == fwg_pkg::V_PERMIT && mkey != fwg_pkg::KEY_CODE_OPEN) begin
         exp  = 2'h3;
         mkey = fwg_pkg::KEY_CODE_DEAD;
      end
      rv        = $random(seed);
      slow      = rv[0];
      dbg_wdata = rv[8:1];
      cpu_wdata = dbg_wdata;
      {dbg_op, dbg_addr, cpu_op, cpu_addr, cpu_pc} = {op, a, op[0], a, pc};
      if (d) dbg_req = 1'b1;
      else cpu_req = 1'b1;
      for (int i = 0; i < 10 && got == 2'h3; i++) begin
         @(posedge core_clk);
         #1;
         if (err_reset === 1'b1) got = fwg_pkg::V_ERROR;
         else if (dbg_refused === 1'b1) got = fwg_pkg::V_REFUSE;
         else if (cmd_valid === 1'b1) got = fwg_pkg::V_PERMIT;
      end
      dbg_req = 1'b0;
      cpu_req = 1'b0;
      check("verdict", exp, got);
      if (got == fwg_pkg::V_PERMIT) begin
         check("cmd_op", eop, cmd_op);
         check("busy", 1'b1, busy);
         if (eop < 2'h2) check("cmd_addr", a, cmd_addr);
         if (eop == 2'h2) check("erase page", a[12:9], cmd_addr[12:9]);
         if (eop == 2'h1) check("cmd_wdata", cpu_wdata, cmd_wdata);
         for (int i = 0; busy !== 1'b0; i++) begin
            if (i == 30) begin
               fail_count++;
               $display("[FAIL] busy expected 0 seen %b", busy);
               test_done();
            end
            @(posedge core_clk);
            #1;
         end
         if (!d && op[0]) mkey = fwg_pkg::KEY_CODE_LOCKED;
      end
   endtask

   initial begin
      {sfr_wr, cpu_req, cpu_op, dbg_req, slow, sfr_addr, sfr_wdata} = '0;
      {cpu_addr, cpu_pc, cpu_wdata, dbg_op, dbg_addr, dbg_wdata} = '0;
      core_clk   = 1'b0;
      seed       = 32'h0000_f247;
      fail_count = 0;
      cmp_count  = 0;
      do_reset(8'hFF, 1'b1);
      sfr_read(fwg_pkg::CTL_OFFSET, fwg_pkg::CTL_RESET);
      sfr_read(fwg_pkg::KEY_OFFSET, fwg_pkg::KEY_RESET);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'hFF);
      sfr_read(fwg_pkg::CTL_OFFSET, 8'h03);
      sfr_write(8'h80, 8'hFF);
      sfr_read(8'h80, 8'h00);
      $display("test registers done");
      key_seq();
      sfr_write(fwg_pkg::CTL_OFFSET, 8'h01);
      do_req(1'b0, 2'h1, rnd_in(4'h3), 13'h0400);
      sfr_read(fwg_pkg::KEY_OFFSET, {6'h00, mkey});
      key_seq();
      do_req(1'b0, 2'h1, fwg_pkg::LOCK_BYTE_ADDR, 13'h0400);
      do_req(1'b1, 2'h0, rnd_in(4'h0), 13'h0000);
      key_seq();
      sfr_write(fwg_pkg::CTL_OFFSET, 8'hFF);
      do_req(1'b0, 2'h1, rnd_in(4'h5), 13'h0400);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'h02);
      do_req(1'b0, 2'h1, rnd_in(4'h5), 13'h0400);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'h01);
      do_req(1'b0, 2'h1, rnd_in(4'h6), 13'h0400);
      key_seq();
      for (int op = 0; op < 4; op++) do_req(1'b1, 2'(op), rnd_in(4'(op + 2)), 13'h0000);
      do_req(1'b1, fwg_pkg::DBG_PAGE_ERASE, fwg_pkg::LOCK_BYTE_ADDR, 13'h0000);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'hFF);
      do_req(1'b0, 2'h1, 13'h1C40, 13'h0400);
      // The flag is set on the edge after the error pulse
      @(posedge core_clk);
      #1;
      check("flag", 1'b1, flash_error_flag);
      $display("test key and unlocked map done");
      do_reset(8'hFD, 1'b1);
      check("flag", 1'b0, flash_error_flag);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'hFF);
      do_req(1'b0, 2'h1, 13'h1C20, 13'h0200);
      sfr_write(fwg_pkg::CTL_OFFSET, 8'h01);
      do_req(1'b0, 2'h1, fwg_pkg::LOCK_BYTE_ADDR, 13'h0300);
      do_req(1'b0, 2'h0, 13'h0100, 13'h0300);
      do_req(1'b0, 2'h0, 13'h0100, 13'h0A00);
      do_req(1'b1, 2'h0, fwg_pkg::LOCK_BYTE_ADDR, 13'h0000);
      do_req(1'b1, 2'h1, 13'h1C10, 13'h0000);
      do_req(1'b0, 2'h0, 13'h1E00, 13'h0300);
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         do_req(r[0], r[2:1], r[15:3], rnd_in(4'(r[31:16] % 16'h000F)));
      end
      $display("test locked map done");
      test_done();
   end
endmodule // fwg_guard_tb
`default_nettype wire
